// ==== inc/dtmfcs_defs.svh ====
// Constants of the DTMF control and status register block
`ifndef DTMFCS_DEFS_SVH
`define DTMFCS_DEFS_SVH
`define DTMFCS_CLK_MHZ        200
`define DTMFCS_BURST_MS       51
`define DTMFCS_BURST_CP_MS    102
`define DTMFCS_CYC_PER_MS     (`DTMFCS_CLK_MHZ * 1000)
`define DTMFCS_BURST_CYC      (`DTMFCS_BURST_MS * `DTMFCS_CYC_PER_MS)
`define DTMFCS_BURST_CP_CYC   (`DTMFCS_BURST_CP_MS * `DTMFCS_CYC_PER_MS)
`define DTMFCS_CNT_W          25
// First control register fields
`define DTMFCS_A_TONE_OUT     0
`define DTMFCS_A_CP_MODE      1
`define DTMFCS_A_IRQ_EN       2
`define DTMFCS_A_B_SELECT     3
// Second control register fields
`define DTMFCS_B_BURST_DIS    0
`define DTMFCS_B_RX_DIS       1
`define DTMFCS_B_SINGLE       2
`define DTMFCS_B_COLUMN       3
// Status fields
`define DTMFCS_S_IRQ          0
`define DTMFCS_S_TX_EMPTY     1
`define DTMFCS_S_RX_FULL      2
`define DTMFCS_S_DELAY_STEER  3
`define DTMFCS_CTRL_RESET     4'h0
`define DTMFCS_B_SOFT_RESET   4'h8
`endif

// ==== inc/dtmfcs_pkg.sv ====
// Types of the DTMF control and status register block
package dtmfcs_pkg;
  typedef enum logic [1:0] {DTMFCS_TX_IDLE, DTMFCS_TX_TONE, DTMFCS_TX_PAUSE} dtmfcs_tx_t;
  typedef enum logic [2:0] {
    DTMFCS_H_IDLE, DTMFCS_H_RESET, DTMFCS_H_STROBE, DTMFCS_H_GAP, DTMFCS_H_BURST
  } dtmfcs_host_t;
endpackage : dtmfcs_pkg

// ==== inc/dtmfcs_if.sv ====
// Parallel host bus between the microprocessor and the DTMF transceiver
`timescale 1ns/1ps
`default_nettype none
interface dtmfcs_if;
  logic       chip_select_n;
  logic       register_select_line;
  logic       read_not_write;
  logic [3:0] data_to_device;
  logic [3:0] data_from_device;
  logic       data_oe;
  logic       irq_out;
  logic       irq_oe;
  logic       irq_n;
  assign irq_n = irq_oe ? irq_out : 1'b1;
  modport device (input chip_select_n, register_select_line, read_not_write,
                  data_to_device, output data_from_device, data_oe, irq_out, irq_oe);
  modport host (output chip_select_n, register_select_line, read_not_write,
                data_to_device, input data_from_device, data_oe, irq_n);
endinterface : dtmfcs_if
`default_nettype wire

// ==== src/dtmfcs_device.sv ====
// Device end: control registers, status flags and burst timing
`timescale 1ns/1ps
`default_nettype none
`include "dtmfcs_defs.svh"
// Function
// - Burst disable bit zero enables burst mode
// - Each tone write gives burst plus pause
// - Pause end sets transmit-empty, may interrupt
// - Call progress mode doubles burst and pause
// - Non-burst tone lasts while tone output enabled
// - Receiver disable powers down both receivers
// - Single tone select picks one tone
// - Column select picks high or low group
// - Both down also stops oscillator and reference
// - Interrupt flag follows empty or full, cleared
// - Transmit-empty only in burst, read clears
// - Receive-full set on valid data, read clears
// - Delayed steering tracks tone absence
// - Host performs software reset after power-up
// - Host burst setup always writes A, then B; B reaches register B only if setup A sets the select bit
// - Host services flags only after an interrupt
// - Register select routes data or control access
// - Select bit steers next control write
// - Interrupt pin low on events in DTMF mode
// - Tone output off clears transmit data
module dtmfcs_device
  import dtmfcs_pkg::*;
#(
  parameter int BURST_CYC    = `DTMFCS_BURST_CYC,
  parameter int BURST_CP_CYC = `DTMFCS_BURST_CP_CYC
) (
  input  wire logic       clock,
  input  wire logic       reset_n,
  dtmfcs_if.device        bus,
  input  wire logic       rx_valid,
  input  wire logic [3:0] rx_code,
  input  wire logic       tone_present,
  output logic [3:0]      tx_code,
  output logic            tone_on,
  output logic            single_tone,
  output logic            column_tone,
  output logic            tx_power_down,
  output logic            rx_power_down,
  output logic            osc_power_down,
  output logic            call_progress_mode
);
  logic [3:0] ctrl_a;
  logic [3:0] ctrl_b;
  logic       b_pending;
  logic [3:0] rx_data;
  logic       tx_empty;
  logic       rx_full;
  logic       delay_steer;
  logic       cs_q;
  logic       access;
  logic       rd_status;
  logic       rd_pend;
  logic       wr_tx;
  logic       pause_done;
  logic [`DTMFCS_CNT_W-1:0] cnt;
  logic [`DTMFCS_CNT_W-1:0] phase_len;
  dtmfcs_tx_t tx_state;
  logic       burst_on;

  // One access per chip-select falling edge
  assign access    = cs_q && !bus.chip_select_n;
  assign rd_status = access && bus.read_not_write && bus.register_select_line;
  assign wr_tx     = access && !bus.read_not_write && !bus.register_select_line;
  assign burst_on  = !ctrl_b[`DTMFCS_B_BURST_DIS];
  assign phase_len = ctrl_a[`DTMFCS_A_CP_MODE] ? `DTMFCS_CNT_W'(BURST_CP_CYC)
                                               : `DTMFCS_CNT_W'(BURST_CYC);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cs_q <= 1'b1;
    end else begin
      cs_q <= bus.chip_select_n;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_a    <= `DTMFCS_CTRL_RESET;
      ctrl_b    <= `DTMFCS_CTRL_RESET;
      b_pending <= 1'b0;
    end else if (access && !bus.read_not_write && bus.register_select_line) begin
      if (b_pending) begin
        ctrl_b    <= bus.data_to_device;
        b_pending <= 1'b0;
      end else begin
        ctrl_a    <= bus.data_to_device;
        b_pending <= bus.data_to_device[`DTMFCS_A_B_SELECT];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_code <= `DTMFCS_CTRL_RESET;
    end else if (!ctrl_a[`DTMFCS_A_TONE_OUT]) begin
      tx_code <= `DTMFCS_CTRL_RESET;
    end else if (wr_tx) begin
      tx_code <= bus.data_to_device;
    end
  end

  // Burst sequencer; a write during a burst restarts it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_state   <= DTMFCS_TX_IDLE;
      cnt        <= '0;
      pause_done <= 1'b0;
    end else begin
      pause_done <= 1'b0;
      if (!burst_on || !ctrl_a[`DTMFCS_A_TONE_OUT]) begin
        tx_state <= DTMFCS_TX_IDLE;
        cnt      <= '0;
      end else if (wr_tx) begin
        tx_state <= DTMFCS_TX_TONE;
        cnt      <= '0;
      end else begin
        unique case (tx_state)
          DTMFCS_TX_IDLE: cnt <= '0;
          DTMFCS_TX_TONE: begin
            if (cnt >= phase_len - 1'b1) begin
              tx_state <= DTMFCS_TX_PAUSE;
              cnt      <= '0;
            end else begin
              cnt <= cnt + 1'b1;
            end
          end
          DTMFCS_TX_PAUSE: begin
            if (cnt >= phase_len - 1'b1) begin
              tx_state   <= DTMFCS_TX_IDLE;
              cnt        <= '0;
              pause_done <= 1'b1;
            end else begin
              cnt <= cnt + 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Clear lands the cycle after the read; a set then still wins
  // Only flags reported by the read are cleared, so one set on the read edge survives
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_pend <= 1'b0;
    end else begin
      rd_pend <= rd_status;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_empty <= 1'b0;
    end else if (!burst_on) begin
      tx_empty <= 1'b0;
    end else if (pause_done) begin
      tx_empty <= 1'b1;
    end else if (rd_pend && bus.data_from_device[`DTMFCS_S_TX_EMPTY]) begin
      tx_empty <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_full <= 1'b0;
      rx_data <= 4'h0;
    end else if (rx_valid && !rx_power_down) begin
      rx_full <= 1'b1;
      rx_data <= rx_code;
    end else if (rd_pend && bus.data_from_device[`DTMFCS_S_RX_FULL]) begin
      rx_full <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      delay_steer <= 1'b0;
    end else begin
      delay_steer <= !tone_present;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bus.data_from_device <= 4'h0;
    end else if (access && bus.read_not_write) begin
      if (bus.register_select_line) begin
        // Snapshot before the clear
        bus.data_from_device <= {delay_steer, rx_full, tx_empty, tx_empty | rx_full};
      end else begin
        bus.data_from_device <= rx_data;
      end
    end
  end

  assign bus.data_oe = !bus.chip_select_n && bus.read_not_write;
  assign bus.irq_out = 1'b0;
  assign bus.irq_oe  = ctrl_a[`DTMFCS_A_IRQ_EN] && !ctrl_a[`DTMFCS_A_CP_MODE]
                       && (tx_empty || rx_full);

  assign tone_on        = ctrl_a[`DTMFCS_A_TONE_OUT]
                          && (!burst_on || tx_state == DTMFCS_TX_TONE);
  assign single_tone    = ctrl_b[`DTMFCS_B_SINGLE];
  assign column_tone    = ctrl_b[`DTMFCS_B_COLUMN];
  assign tx_power_down  = !ctrl_a[`DTMFCS_A_TONE_OUT];
  assign rx_power_down  = ctrl_b[`DTMFCS_B_RX_DIS];
  assign osc_power_down = tx_power_down && rx_power_down;
  assign call_progress_mode = ctrl_a[`DTMFCS_A_CP_MODE];
endmodule : dtmfcs_device
`default_nettype wire

// ==== src/dtmfcs_host.sv ====
// Host end: software reset, burst setup and flag servicing
`timescale 1ns/1ps
`default_nettype none
`include "dtmfcs_defs.svh"
module dtmfcs_host
  import dtmfcs_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  dtmfcs_if.host          bus,
  input  wire logic       start,
  input  wire logic [3:0] setup_a,
  input  wire logic [3:0] setup_b,
  input  wire logic       tone_valid,
  input  wire logic [3:0] tone_code,
  output logic            tone_ready,
  output logic            busy,
  output logic [3:0]      rx_digit,
  output logic            rx_digit_valid
);
  dtmfcs_host_t state;
  logic [3:0]   step;
  logic [3:0]   op_rs_rw_d;
  logic [3:0]   op_data;
  logic         op_rd;
  logic         op_rs;
  logic         got_tx;
  logic         want_rx;
  logic         wait_rx;

  // Script: steps 0-5 reset 6-7 burst setup
  function automatic logic [5:0] script(input logic [3:0] s, input logic [3:0] a,
                                        input logic [3:0] b);
    unique case (s)
      4'h0: script = {1'b1, 1'b1, 4'h0};
      4'h1: script = {1'b1, 1'b0, `DTMFCS_CTRL_RESET};
      4'h2: script = {1'b1, 1'b0, `DTMFCS_CTRL_RESET};
      4'h3: script = {1'b1, 1'b0, `DTMFCS_B_SOFT_RESET};
      4'h4: script = {1'b1, 1'b0, `DTMFCS_CTRL_RESET};
      4'h5: script = {1'b1, 1'b1, 4'h0};
      4'h6: script = {1'b1, 1'b0, a};
      default: script = {1'b1, 1'b0, b};
    endcase
  endfunction : script

  assign busy       = state != DTMFCS_H_BURST;
  assign tone_ready = state == DTMFCS_H_BURST && got_tx;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state              <= DTMFCS_H_IDLE;
      step               <= 4'h0;
      bus.chip_select_n  <= 1'b1;
      bus.register_select_line <= 1'b0;
      bus.read_not_write <= 1'b1;
      bus.data_to_device <= 4'h0;
      got_tx             <= 1'b1;
      want_rx            <= 1'b0;
      wait_rx            <= 1'b0;
      rx_digit           <= 4'h0;
      rx_digit_valid     <= 1'b0;
    end else begin
      rx_digit_valid <= 1'b0;
      unique case (state)
        DTMFCS_H_IDLE: if (start) begin
          state <= DTMFCS_H_RESET;
          step  <= 4'h0;
        end
        DTMFCS_H_RESET: begin
          {bus.register_select_line, bus.read_not_write, bus.data_to_device}
            <= script(step, setup_a, setup_b);
          bus.chip_select_n <= 1'b0;
          state <= DTMFCS_H_STROBE;
        end
        DTMFCS_H_STROBE: begin
          bus.chip_select_n <= 1'b1;
          state <= DTMFCS_H_GAP;
        end
        DTMFCS_H_GAP: begin
          // Read data is registered on the strobe edge, so it is taken one cycle later
          if (wait_rx && bus.read_not_write && !bus.register_select_line) begin
            rx_digit       <= bus.data_from_device;
            rx_digit_valid <= 1'b1;
            wait_rx        <= 1'b0;
          end
          if (bus.read_not_write && bus.register_select_line && step == 4'hF) begin
            got_tx  <= got_tx | bus.data_from_device[`DTMFCS_S_TX_EMPTY];
            want_rx <= bus.data_from_device[`DTMFCS_S_RX_FULL];
          end
          if (step == 4'h7) begin
            step  <= 4'hF;
            state <= DTMFCS_H_BURST;
          end else if (step == 4'hF) begin
            state <= DTMFCS_H_BURST;
          end else begin
            step  <= step + 4'h1;
            state <= DTMFCS_H_RESET;
          end
        end
        DTMFCS_H_BURST: begin
          // New setup restarts the reset script; the device is then ready to send
          if (start) begin
            state   <= DTMFCS_H_RESET;
            step    <= 4'h0;
            got_tx  <= 1'b1;
            want_rx <= 1'b0;
          end else if (want_rx) begin
            want_rx <= 1'b0;
            wait_rx <= 1'b1;
            bus.register_select_line <= 1'b0;
            bus.read_not_write <= 1'b1;
            bus.chip_select_n  <= 1'b0;
            state <= DTMFCS_H_STROBE;
          end else if (got_tx && tone_valid) begin
            got_tx <= 1'b0;
            bus.register_select_line <= 1'b0;
            bus.read_not_write <= 1'b0;
            bus.data_to_device <= tone_code;
            bus.chip_select_n  <= 1'b0;
            state <= DTMFCS_H_STROBE;
          end else if (!bus.irq_n) begin
            bus.register_select_line <= 1'b1;
            bus.read_not_write <= 1'b1;
            bus.chip_select_n  <= 1'b0;
            state <= DTMFCS_H_STROBE;
          end
        end
        default: state <= DTMFCS_H_IDLE;
      endcase
    end
  end
endmodule : dtmfcs_host
`default_nettype wire

// ==== tb/dtmfcs_asserts.sv ====
// Concurrent checks on the host bus between the two ends
`timescale 1ns/1ps
`default_nettype none
module dtmfcs_asserts (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic       chip_select_n,
  input wire logic       register_select_line,
  input wire logic       read_not_write,
  input wire logic [3:0] data_to_device,
  input wire logic [3:0] data_from_device,
  input wire logic       data_oe,
  input wire logic       irq_out,
  input wire logic       irq_oe,
  input wire logic       irq_n
);
  logic       cs_q;
  logic       to_b;
  logic [3:0] ctrl_a;
  logic [3:0] ctrl_b;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Shadow of both control registers, so mode-dependent checks know the mode
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cs_q <= 1'b1;
      to_b <= 1'b0;
      ctrl_a <= 4'h0;
      ctrl_b <= 4'h0;
    end else begin
      cs_q <= chip_select_n;
      if (cs_q && !chip_select_n && !read_not_write && register_select_line) begin
        if (to_b) begin
          ctrl_b <= data_to_device;
          to_b <= 1'b0;
        end else begin
          ctrl_a <= data_to_device;
          to_b <= data_to_device[3];
        end
      end
    end
  end
  sequence s_read_take;
    $fell(chip_select_n) && read_not_write;
  endsequence
  sequence s_status_take;
    $fell(chip_select_n) && read_not_write && register_select_line;
  endsequence
  data_oe_a: assert property (data_oe == (!chip_select_n && read_not_write))
    else $error("data enable differs from read strobe");
  rd_enable_a: assert property (s_read_take |-> data_oe)
    else $error("data bus not enabled on a read");
  irq_od_a: assert property (irq_out == 1'b0)
    else $error("interrupt pin driven high");
  irq_pin_a: assert property (irq_n == !irq_oe)
    else $error("interrupt level differs from its enable");
  cs_pulse_a: assert property ($fell(chip_select_n) |=> chip_select_n)
    else $error("select held low beyond one cycle");
  data_hold_a: assert property (!($fell(chip_select_n) && read_not_write)
    |=> $stable(data_from_device))
    else $error("read data moved without a read");
  status_or_a: assert property (s_status_take
    |=> data_from_device[0] == (data_from_device[1] | data_from_device[2]))
    else $error("interrupt flag not the or of the flags");
  burst_off_a: assert property (s_status_take ##0 ctrl_b[0] |=> !data_from_device[1])
    else $error("transmit empty outside burst mode");
  irq_gate_a: assert property (irq_oe |-> ctrl_a[2] && !ctrl_a[1])
    else $error("interrupt without enable or in tone analysis mode");
  irq_flag_a: assert property (s_status_take ##0 irq_oe |=> data_from_device[0])
    else $error("pending interrupt missing from status");
endmodule : dtmfcs_asserts
`default_nettype wire

// ==== tb/dtmf_control_status_regs_tb.sv ====
// Bench joining host and device ends, with bus assertions
`timescale 1ns/1ps
`default_nettype none
module dtmf_control_status_regs_tb;
  localparam int BURST = 20;
  localparam int BURST_CP = 40;
  logic       clock, reset_n, start, tone_valid, rx_valid, tone_present, irq_line;
  logic [3:0] setup_a, setup_b, tone_code, rx_code, rx_digit, tx_code;
  logic       tone_ready, busy, rx_digit_valid, tone_on, single_tone, column_tone;
  logic       tx_power_down, rx_power_down, osc_power_down, call_progress_mode;
  logic [3:0] cfg_a [4] = '{4'hD, 4'hF, 4'hC, 4'h9};
  logic [3:0] cfg_b [4] = '{4'h0, 4'h0, 4'h3, 4'h1};
  int         failures, samples_checked, seed, i;
  int         rx_q [$];
  dtmfcs_if bus ();
  assign irq_line = bus.irq_n;
  dtmfcs_host i_dtmfcs_host (.clock(clock), .reset_n(reset_n), .bus(bus), .start(start),
    .setup_a(setup_a), .setup_b(setup_b), .tone_valid(tone_valid), .tone_code(tone_code),
    .tone_ready(tone_ready), .busy(busy), .rx_digit(rx_digit), .rx_digit_valid(rx_digit_valid));
  dtmfcs_device #(.BURST_CYC(BURST), .BURST_CP_CYC(BURST_CP)) i_dtmfcs_device (.clock(clock),
    .reset_n(reset_n), .bus(bus), .rx_valid(rx_valid), .rx_code(rx_code),
    .tone_present(tone_present), .tx_code(tx_code), .tone_on(tone_on),
    .single_tone(single_tone), .column_tone(column_tone), .tx_power_down(tx_power_down),
    .rx_power_down(rx_power_down), .osc_power_down(osc_power_down),
    .call_progress_mode(call_progress_mode));
  dtmfcs_asserts i_dtmfcs_asserts (.clock(clock), .reset_n(reset_n),
    .chip_select_n(bus.chip_select_n), .register_select_line(bus.register_select_line),
    .read_not_write(bus.read_not_write), .data_to_device(bus.data_to_device),
    .data_from_device(bus.data_from_device), .data_oe(bus.data_oe), .irq_out(bus.irq_out),
    .irq_oe(bus.irq_oe), .irq_n(bus.irq_n));
  task automatic check_nib(input logic [3:0] got, input logic [3:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : check_nib
  task automatic check_count(input int got, input int exp, input string m);
    samples_checked++;
    if (got != exp) begin
      failures++;
      $display("wrong value at %0t: %s got %0d expected %0d", $time, m, got, exp);
    end
  endtask : check_count
  task automatic print_verdict;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  function automatic logic probe(input int w);
    case (w)
      0: return tone_on;
      1: return irq_line;
      2: return tone_ready;
      3: return rx_digit_valid;
      default: return busy;
    endcase
  endfunction : probe
  task automatic wait_sig(input int w, input logic lvl, input int lim);
    int k;
    k = 0;
    while (probe(w) !== lvl && k < lim) begin
      @(posedge clock);
      #1;
      k++;
    end
    check_nib({3'b000, probe(w)}, {3'b000, lvl}, "wait ran out");
  endtask : wait_sig
  task automatic run_setup(input logic [3:0] a, input logic [3:0] b);
    @(negedge clock);
    setup_a = a;
    setup_b = b;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    wait_sig(4, 1'b0, 200);
    check_nib({single_tone, column_tone, rx_power_down, tx_power_down},
      {b[2], b[3], b[1], !a[0]}, "modes");
    check_nib({osc_power_down, call_progress_mode, 2'b00},
      {!a[0] && b[1], a[1], 2'b00}, "power");
    if (!a[0]) check_nib(tx_code, 4'h0, "tx cleared");
  endtask : run_setup
  task automatic send_tone(input logic [3:0] code, input int len, input bit irq_exp);
    int k;
    @(negedge clock);
    tone_code = code;
    tone_valid = 1'b1;
    k = 0;
    @(posedge clock);
    while (tone_ready !== 1'b1 && k < 200) begin
      @(posedge clock);
      k++;
    end
    @(negedge clock);
    tone_valid = 1'b0;
    wait_sig(0, 1'b1, 20);
    check_nib(tx_code, code, "tone code");
    k = 0;
    while (tone_on === 1'b1 && k < 200) begin
      @(posedge clock);
      #1;
      k++;
    end
    check_count(k, len, "burst length");
    k = 0;
    while (irq_line === 1'b1 && k < 3 * len) begin
      @(posedge clock);
      #1;
      k++;
    end
    // Pause end to pin allows two cycles of flag and pin latency
    if (irq_exp) check_count(int'(k >= len && k <= len + 2), 1, "pause length");
    else check_count(k, 3 * len, "no interrupt");
    if (irq_exp) wait_sig(2, 1'b1, 50);
  endtask : send_tone
  task automatic recv(input logic [3:0] code);
    @(negedge clock);
    rx_code = code;
    rx_valid = 1'b1;
    rx_q.push_back(code);
    @(negedge clock);
    rx_valid = 1'b0;
    wait_sig(3, 1'b1, 100);
    check_nib(rx_digit, 4'(rx_q.pop_front()), "digit");
  endtask : recv
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Steering input wanders so the delayed steering path is exercised
  always @(negedge clock) tone_present <= 1'($random(seed));
  initial begin
    #100000;
    failures++;
    $display("wrong value at %0t: run did not finish", $time);
    print_verdict();
  end
  initial begin
    seed = 32'hE353;
    {reset_n, start, tone_valid, rx_valid} = 4'b0000;
    {setup_a, setup_b, tone_code, rx_code} = 16'h0000;
    repeat (8) @(posedge clock);
    @(negedge clock);
    reset_n = 1'b1;
    for (i = 0; i < 4; i++) begin
      run_setup(cfg_a[i], cfg_b[i] | (4'($random(seed)) & 4'hC));
      if (i == 0) begin
        send_tone(4'($random(seed)), BURST, 1'b1);
        recv(4'($random(seed)));
        send_tone(4'($random(seed)), BURST, 1'b1);
      end
      if (i == 1) send_tone(4'($random(seed)), BURST_CP, 1'b0);
      // Non-burst tone must outlast any fixed burst interval
      if (i == 3) begin
        repeat (BURST_CP) @(negedge clock);
        wait_sig(0, 1'b1, 1);
      end
      $display("test %0d done", i);
    end
    print_verdict();
  end
endmodule : dtmf_control_status_regs_tb
`default_nettype wire
